/* File: inc/prc_pkg.sv */
// package: register map, defaults, timing and carrier types of the rail control bank
package prc_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h02;
  localparam logic [7:0] ADDR_RAIL_EN = 8'h03;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h05;
  localparam logic [7:0] ADDR_CORE_CODE = 8'h06;

  // values loaded by lockout or the wider reset events
  localparam logic [7:0] RST_FAULT_MASK = 8'hC0;
  localparam logic [7:0] RST_RAIL_EN = 8'hFF;
  localparam logic [7:0] RST_MODE_CTRL = 8'hB1;
  localparam logic [7:0] RST_CTRL2 = 8'h40;
  localparam logic [4:0] CORE_CODE_PIN_LOW = 5'h14;
  localparam logic [4:0] CORE_CODE_PIN_HIGH = 5'h1E;

  // field positions, second control register
  localparam int CTRL2_GO = 7;
  localparam int CTRL2_PIN_SRC = 6;
  localparam int CTRL2_DIS_SYS = 2;
  localparam int CTRL2_DIS_CORE = 1;
  localparam int CTRL2_DIS_MEM = 0;

  // field positions, mode control register
  localparam int MODE_SYS_PH_LO = 6;
  localparam int MODE_MEM_PH_LO = 4;
  localparam int MODE_LOW_RIPPLE = 3;
  localparam int MODE_FIX_SYS = 2;
  localparam int MODE_FIX_CORE = 1;
  localparam int MODE_FIX_MEM = 0;

  // field positions, rail enable register
  localparam int EN_CORE = 5;
  localparam int EN_SYS = 4;
  localparam int EN_MEM = 3;
  localparam int EN_LDO2 = 2;
  localparam int EN_LDO1 = 1;

  // read value of the unused rail enable bits
  localparam logic [7:0] RAIL_EN_FIXED_ONES = 8'hC1;

  // clock and voltage ramp timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CORE_STEP_UV = 25000;
  localparam int STRAP_SETTLE_CYCLES = 5;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;

  // synchroniser bit positions and their reset levels
  localparam int PIN_COUNT = 9;
  localparam int PIN_CORE_EN = 0;
  localparam int PIN_SYS_EN = 1;
  localparam int PIN_MEM_EN = 2;
  localparam int PIN_LINEAR_REG_ENABLE_PIN = 3;
  localparam int PIN_DEF_SEL = 4;
  localparam int PIN_UNDERVOLTAGE_LOCKOUT = 5;
  localparam int PIN_WARM_N = 6;
  localparam int PIN_POR = 7;
  localparam int PIN_BACKUP_LOW = 8;
  localparam logic [8:0] PIN_RST_LEVEL = 9'h040;

  // slew rates of the core ramp, microvolt per microsecond
  localparam int SLEW_UV_PER_US [0:6] = '{225, 450, 900, 1800, 3600, 7200, 14400};

  // cycles spent on one code step for a slew setting, at least one
  function automatic logic [15:0] prc_step_cycles(input logic [2:0] slew);
    int ns;
    ns = 0;
    if (slew == SLEW_IMMEDIATE) begin
      return 16'h0001;
    end
    ns = (CORE_STEP_UV * 1000) / SLEW_UV_PER_US[slew];
    return (ns / CLK_PERIOD_NS < 1) ? 16'h0001 : 16'(ns / CLK_PERIOD_NS);
  endfunction

  // rail on states
  typedef struct packed {
    logic core;
    logic system;
    logic memory;
    logic ldo2;
    logic ldo1;
  } prc_rails_t;

  // converter operating controls
  typedef struct packed {
    logic [1:0] system_converter_phase;
    logic [1:0] memory_converter_phase;
    logic low_ripple;
    logic [2:0] forced_fixed_frequency;
  } prc_mode_t;

  // ramp sequencer states
  typedef enum logic [1:0] {
    DVT_IDLE = 2'b00,
    DVT_RAMP = 2'b01
  } prc_dvt_state_t;

endpackage

/* File: rtl/prc_regs.sv */
// module: rail enable, converter mode and core voltage control registers
//
// Contract
// - rail on needs register bit and pin high
// - enable bits load 1 on lockout, writable
// - pin low forces its enable bit to 1
// - one linear pin forces and gates both
// - phase fields delay system and memory converters
// - core converter always zero phase reference
// - bit 3 selects low ripple light load
// - bits 2..0 force fixed frequency mode
// - go bit ramps core to code register
// - go clears when stepped code reaches target
// - bit 6 selects pin or register voltage
// - bit 6 and code reload on reset events
// - discharge bits discharge disabled converters
// - code 0 is 0.8 V, 25 mV steps
// - code default 14h or 1Eh by pin
// - mode register all writable, default B1h
// - second register default 40h, go self clears
module prc_regs
  import prc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // enable pins
  input wire logic core_rail_enable_pin,
  input wire logic system_rail_enable_pin,
  input wire logic memory_rail_enable_pin,
  input wire logic linear_reg_enable_pin,
  // supervisor and strap inputs
  input wire logic core_default_select_pin,
  input wire logic undervoltage_lockout,
  input wire logic warm_reset_input_n,
  input wire logic power_on_reset_output,
  input wire logic backup_rail_low,
  // slew setting of the ramp
  input wire logic [2:0] core_slew_setting,
  // converter controls
  output prc_rails_t rail_on,
  output prc_rails_t discharge,
  output prc_mode_t mode,
  output logic [1:0] core_converter_phase,
  output logic [4:0] core_converter_output,
  output logic core_voltage_from_pin,
  output logic [7:0] fault_mask
);

  // raw pin bundle
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s1;
  logic [PIN_COUNT-1:0] pin_s2;
  logic [PIN_COUNT-1:0] pin_s3;
  logic [PIN_COUNT-1:0] pin_q;

  // register storage and ramp state
  logic [7:0] fault_interrupt_mask;
  logic [7:0] rail_enable_control;
  logic [7:0] converter_mode_control;
  logic [7:0] converter_control_second;
  logic [4:0] core_voltage_code;
  logic [4:0] stepped_code;
  logic [15:0] step_cnt;
  logic [2:0] settle_cnt;
  prc_dvt_state_t dvt_state;
  prc_dvt_state_t next_dvt_state;

  // reset events and ramp helpers
  logic lockout;
  logic wide_reset;
  logic strap_load;
  logic [4:0] code_default;
  logic go_done;
  logic step_now;

  // write strobe decode, shared by every register
  function automatic logic hit(input logic [7:0] addr);
    return reg_wr && (reg_addr == addr);
  endfunction

  // pins gathered into one bundle for the synchronisers
  assign pin_raw = {backup_rail_low, power_on_reset_output, warm_reset_input_n,
                    undervoltage_lockout, core_default_select_pin, linear_reg_enable_pin,
                    memory_rail_enable_pin, system_rail_enable_pin, core_rail_enable_pin};

  // three stage synchronisers, filtered value moves when stages two and three agree
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        pin_s1[i] <= PIN_RST_LEVEL[i];
        pin_s2[i] <= PIN_RST_LEVEL[i];
        pin_s3[i] <= PIN_RST_LEVEL[i];
        pin_q[i] <= PIN_RST_LEVEL[i];
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end

  // strap settle window after reset release
  // window outlasts the synchroniser so the settled strap level is loaded
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt <= 3'h0;
    end else if (settle_cnt != 3'(STRAP_SETTLE_CYCLES)) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  // refuse a strap window the counter cannot hold or the synchroniser outlasts
  if (STRAP_SETTLE_CYCLES < SYNC_STAGES + 2 || STRAP_SETTLE_CYCLES > 7) begin : g_bad_settle
    $error("strap settle window does not fit the synchroniser");
  end

  // reset event decode
  assign strap_load = (settle_cnt != 3'(STRAP_SETTLE_CYCLES));
  assign lockout = pin_q[PIN_UNDERVOLTAGE_LOCKOUT];
  assign wide_reset = lockout || !pin_q[PIN_WARM_N] || pin_q[PIN_POR]
                      || pin_q[PIN_BACKUP_LOW] || strap_load;
  assign code_default = pin_q[PIN_DEF_SEL] ? CORE_CODE_PIN_HIGH : CORE_CODE_PIN_LOW;

  // fault mask storage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_interrupt_mask <= RST_FAULT_MASK;
    end else if (lockout) begin
      fault_interrupt_mask <= RST_FAULT_MASK;
    end else if (hit(ADDR_FAULT_MASK)) begin
      fault_interrupt_mask <= reg_wdata;
    end
  end

  // rail enables: lockout loads ones, low pin forces one over a write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rail_enable_control <= RST_RAIL_EN;
    end else if (lockout) begin
      rail_enable_control <= RST_RAIL_EN;
    end else begin
      if (hit(ADDR_RAIL_EN)) begin
        rail_enable_control <= reg_wdata | RAIL_EN_FIXED_ONES;
      end
      if (!pin_q[PIN_CORE_EN]) begin
        rail_enable_control[EN_CORE] <= 1'b1;
      end
      if (!pin_q[PIN_SYS_EN]) begin
        rail_enable_control[EN_SYS] <= 1'b1;
      end
      if (!pin_q[PIN_MEM_EN]) begin
        rail_enable_control[EN_MEM] <= 1'b1;
      end
      if (!pin_q[PIN_LINEAR_REG_ENABLE_PIN]) begin
        rail_enable_control[EN_LDO2] <= 1'b1;
        rail_enable_control[EN_LDO1] <= 1'b1;
      end
    end
  end

  // mode control, every bit writable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      converter_mode_control <= RST_MODE_CTRL;
    end else if (lockout) begin
      converter_mode_control <= RST_MODE_CTRL;
    end else if (hit(ADDR_MODE_CTRL)) begin
      converter_mode_control <= reg_wdata;
    end
  end

  // second control register; a go write wins over the self clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      converter_control_second <= RST_CTRL2;
    end else if (lockout) begin
      converter_control_second <= RST_CTRL2;
    end else begin
      if (go_done) begin
        converter_control_second[CTRL2_GO] <= 1'b0;
      end
      if (wide_reset) begin
        converter_control_second[CTRL2_PIN_SRC] <= RST_CTRL2[CTRL2_PIN_SRC];
      end
      if (hit(ADDR_CTRL2)) begin
        converter_control_second[CTRL2_GO] <= reg_wdata[CTRL2_GO];
        converter_control_second[CTRL2_DIS_SYS] <= reg_wdata[CTRL2_DIS_SYS];
        converter_control_second[CTRL2_DIS_CORE] <= reg_wdata[CTRL2_DIS_CORE];
        converter_control_second[CTRL2_DIS_MEM] <= reg_wdata[CTRL2_DIS_MEM];
        if (!wide_reset) begin
          converter_control_second[CTRL2_PIN_SRC] <= reg_wdata[CTRL2_PIN_SRC];
        end
      end
    end
  end

  // core voltage code register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_voltage_code <= CORE_CODE_PIN_LOW;
    end else if (wide_reset) begin
      core_voltage_code <= code_default;
    end else if (hit(ADDR_CORE_CODE)) begin
      core_voltage_code <= reg_wdata[4:0];
    end
  end

  // ramp sequencer: one code step per slew interval, a single jump to the target at the immediate setting
  assign step_now = (step_cnt <= 16'h0001);
  assign go_done = (dvt_state == DVT_RAMP) && (stepped_code == core_voltage_code);

  always_comb begin
    next_dvt_state = dvt_state;
    case (dvt_state)
      DVT_IDLE: begin
        if (converter_control_second[CTRL2_GO]) begin
          next_dvt_state = DVT_RAMP;
        end
      end
      DVT_RAMP: begin
        if (go_done || !converter_control_second[CTRL2_GO]) begin
          next_dvt_state = DVT_IDLE;
        end
      end
      default: begin
        next_dvt_state = DVT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dvt_state <= DVT_IDLE;
    end else if (lockout) begin
      dvt_state <= DVT_IDLE;
    end else begin
      dvt_state <= next_dvt_state;
    end
  end

  // step interval counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      step_cnt <= 16'h0001;
    end else if (dvt_state != DVT_RAMP || step_now) begin
      step_cnt <= prc_step_cycles(core_slew_setting);
    end else begin
      step_cnt <= step_cnt - 16'h0001;
    end
  end

  // stepped code walks toward the target one 25 mV code at a time, or jumps to it at the immediate slew setting
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stepped_code <= CORE_CODE_PIN_LOW;
    end else if (wide_reset) begin
      stepped_code <= code_default;
    end else if (dvt_state == DVT_RAMP && step_now && !go_done) begin
      if (core_slew_setting == SLEW_IMMEDIATE) begin
        stepped_code <= core_voltage_code;
      end else if (stepped_code < core_voltage_code) begin
        stepped_code <= stepped_code + 5'h01;
      end else begin
        stepped_code <= stepped_code - 5'h01;
      end
    end
  end

  // registered converter controls
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rail_on <= '0;
      discharge <= '0;
      mode <= '0;
      core_converter_output <= CORE_CODE_PIN_LOW;
      core_voltage_from_pin <= 1'b0;
      core_converter_phase <= 2'h0;
      fault_mask <= RST_FAULT_MASK;
    end else begin
      rail_on.core <= rail_enable_control[EN_CORE] && pin_q[PIN_CORE_EN];
      rail_on.system <= rail_enable_control[EN_SYS] && pin_q[PIN_SYS_EN];
      rail_on.memory <= rail_enable_control[EN_MEM] && pin_q[PIN_MEM_EN];
      rail_on.ldo2 <= rail_enable_control[EN_LDO2] && pin_q[PIN_LINEAR_REG_ENABLE_PIN];
      rail_on.ldo1 <= rail_enable_control[EN_LDO1] && pin_q[PIN_LINEAR_REG_ENABLE_PIN];
      discharge.core <= converter_control_second[CTRL2_DIS_CORE]
                        && !(rail_enable_control[EN_CORE] && pin_q[PIN_CORE_EN]);
      discharge.system <= converter_control_second[CTRL2_DIS_SYS]
                          && !(rail_enable_control[EN_SYS] && pin_q[PIN_SYS_EN]);
      discharge.memory <= converter_control_second[CTRL2_DIS_MEM]
                          && !(rail_enable_control[EN_MEM] && pin_q[PIN_MEM_EN]);
      discharge.ldo2 <= 1'b0;
      discharge.ldo1 <= 1'b0;
      mode.system_converter_phase <= converter_mode_control[MODE_SYS_PH_LO +: 2];
      mode.memory_converter_phase <= converter_mode_control[MODE_MEM_PH_LO +: 2];
      mode.low_ripple <= converter_mode_control[MODE_LOW_RIPPLE];
      mode.forced_fixed_frequency <= {converter_mode_control[MODE_FIX_SYS],
                                      converter_mode_control[MODE_FIX_CORE],
                                      converter_mode_control[MODE_FIX_MEM]};
      core_converter_phase <= 2'h0;
      core_converter_output <= stepped_code;
      core_voltage_from_pin <= converter_control_second[CTRL2_PIN_SRC];
      fault_mask <= fault_interrupt_mask;
    end
  end

  // read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == ADDR_FAULT_MASK) begin
          reg_rdata <= fault_interrupt_mask;
        end else if (reg_addr == ADDR_RAIL_EN) begin
          reg_rdata <= rail_enable_control;
        end else if (reg_addr == ADDR_MODE_CTRL) begin
          reg_rdata <= converter_mode_control;
        end else if (reg_addr == ADDR_CTRL2) begin
          reg_rdata <= converter_control_second;
        end else if (reg_addr == ADDR_CORE_CODE) begin
          reg_rdata <= {3'h0, core_voltage_code};
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end

endmodule

/* File: tb/prc_regs_properties.sv */
// checker: port-level properties of the rail control register bank
module prc_regs_properties
  import prc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // pins and supervisor inputs
  input wire logic system_rail_enable_pin,
  input wire logic memory_rail_enable_pin,
  input wire logic linear_reg_enable_pin,
  input wire logic undervoltage_lockout,
  input wire logic warm_reset_input_n,
  input wire logic power_on_reset_output,
  input wire logic backup_rail_low,
  // converter controls
  input wire prc_rails_t rail_on,
  input wire prc_rails_t discharge,
  input wire prc_mode_t mode,
  input wire logic [1:0] core_converter_phase,
  input wire logic core_voltage_from_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // no reload event active at the pins
  wire logic quiet;
  assign quiet = !undervoltage_lockout && warm_reset_input_n && !power_on_reset_output
    && !backup_rail_low;
  // properties
  a_core_phase_ref: assert property (core_converter_phase == 2'h0)
    else $error("core phase not zero");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_mode_write: assert property (quiet [*6] ##0 (reg_wr && reg_addr == ADDR_MODE_CTRL)
    |-> ##2 mode == $past(reg_wdata, 2)) else $error("mode not written");
  a_source_write: assert property (quiet [*6] ##0 (reg_wr && reg_addr == ADDR_CTRL2)
    |-> ##2 core_voltage_from_pin == $past(reg_wdata[CTRL2_PIN_SRC], 2))
    else $error("source bit not written");
  a_rail_gate: assert property ((!system_rail_enable_pin) [*6] |-> !rail_on.system)
    else $error("rail on with pin low");
  a_ldo_gate: assert property ((!linear_reg_enable_pin) [*6] |-> !rail_on.ldo1 && !rail_on.ldo2)
    else $error("linear rail on with pin low");
  a_pin_forces: assert property ((!system_rail_enable_pin) [*6] ##0
    (reg_rd && reg_addr == ADDR_RAIL_EN) |=> reg_rdata[EN_SYS]) else $error("bit not forced");
  a_rail_write: assert property ((memory_rail_enable_pin && quiet) [*6] ##0
    (reg_wr && reg_addr == ADDR_RAIL_EN) |-> ##2 rail_on.memory == $past(reg_wdata[EN_MEM], 2))
    else $error("rail bit not written");
  a_discharge_off: assert property (rail_on.system [*2] |-> !discharge.system)
    else $error("discharge on a running rail");
  // main scenarios
  c_mode_write: cover property (reg_wr && reg_addr == ADDR_MODE_CTRL);
  c_pin_forced: cover property ((!system_rail_enable_pin) [*6] ##0 reg_rd);
  c_discharge: cover property (discharge.core);
endmodule

bind prc_regs prc_regs_properties u_props (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_rvalid, .system_rail_enable_pin, .memory_rail_enable_pin,
  .linear_reg_enable_pin, .undervoltage_lockout, .warm_reset_input_n,
  .power_on_reset_output, .backup_rail_low, .rail_on, .discharge, .mode,
  .core_converter_phase, .core_voltage_from_pin);

/* File: tb/tb_pmic_rail_control_registers.sv */
// testbench: register access, pin gating, ramp and reload events of the rail bank
module tb_pmic_rail_control_registers
  import prc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, nrst, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_mask, rdat;
  logic core_rail_enable_pin, system_rail_enable_pin, memory_rail_enable_pin;
  logic linear_reg_enable_pin, core_default_select_pin, undervoltage_lockout;
  logic warm_reset_input_n, power_on_reset_output, backup_rail_low, core_voltage_from_pin;
  logic [2:0] core_slew_setting;
  logic [1:0] core_converter_phase;
  logic [4:0] core_converter_output;
  prc_rails_t rail_on, discharge;
  prc_mode_t mode;
  logic [7:0] mv [5] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h96};
  int fail_count, checks, n;

  prc_regs dut (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .core_rail_enable_pin, .system_rail_enable_pin, .memory_rail_enable_pin,
    .linear_reg_enable_pin, .core_default_select_pin, .undervoltage_lockout,
    .warm_reset_input_n, .power_on_reset_output, .backup_rail_low, .core_slew_setting,
    .rail_on, .discharge, .mode, .core_converter_phase, .core_converter_output,
    .core_voltage_from_pin, .fault_mask);

  // clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // shared helpers
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic peek(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    rdat = reg_rdata;
    cmp("rvalid", 8'h01, {7'h0, reg_rvalid});
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    peek(a);
    cmp($sformatf("reg %h", a), exp, rdat);
  endtask
  task automatic wait_go();
    n = 0;
    do begin
      peek(ADDR_CTRL2);
      n += 2;
    end while (rdat[CTRL2_GO] !== 1'b0 && n < 400);
  endtask
  task automatic defaults();
    rd(ADDR_FAULT_MASK, 8'hC0);
    rd(ADDR_RAIL_EN, 8'hFF);
    rd(ADDR_MODE_CTRL, 8'hB1);
    rd(ADDR_CTRL2, 8'h40);
    rd(ADDR_CORE_CODE, 8'h14);
    cmp("mode", 8'hB1, mode);
    cmp("rails", 8'h1F, {3'h0, rail_on});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, core_default_select_pin} = '0;
    {undervoltage_lockout, power_on_reset_output, backup_rail_low} = '0;
    {core_rail_enable_pin, system_rail_enable_pin, memory_rail_enable_pin} = '1;
    {linear_reg_enable_pin, warm_reset_input_n} = '1;
    core_slew_setting = 3'h7;
    fail_count = 0;
    checks = 0;
    tick(5);
    nrst = 1'b1;
    tick(8);
    defaults();
    cmp("core out", 8'h14, {3'h0, core_converter_output});
    cmp("from pin", 8'h01, {7'h0, core_voltage_from_pin});
    wr(ADDR_FAULT_MASK, 8'h3F);
    cmp("mask", 8'h3F, fault_mask);
    rd(8'h07, 8'h00);
    foreach (mv[i]) begin
      wr(ADDR_MODE_CTRL, mv[i]);
      rd(ADDR_MODE_CTRL, mv[i]);
      cmp("mode", mv[i], mode);
    end
    // register gating and pin forcing
    wr(ADDR_RAIL_EN, 8'h00);
    rd(ADDR_RAIL_EN, 8'hC1);
    cmp("rails off", 8'h00, {3'h0, rail_on});
    system_rail_enable_pin = 1'b0;
    linear_reg_enable_pin = 1'b0;
    tick(8);
    rd(ADDR_RAIL_EN, 8'hD7);
    wr(ADDR_RAIL_EN, 8'h00);
    rd(ADDR_RAIL_EN, 8'hD7);
    cmp("rails gated", 8'h00, {3'h0, rail_on});
    system_rail_enable_pin = 1'b1;
    linear_reg_enable_pin = 1'b1;
    tick(8);
    cmp("rails back", 8'h0B, {3'h0, rail_on});
    // discharge and voltage source
    wr(ADDR_CTRL2, 8'h7F);
    rd(ADDR_CTRL2, 8'h47);
    cmp("discharge", 8'h14, {3'h0, discharge});
    wr(ADDR_CTRL2, 8'h07);
    cmp("from pin", 8'h00, {7'h0, core_voltage_from_pin});
    // immediate then stepped transitions
    wr(ADDR_CORE_CODE, 8'hE5);
    rd(ADDR_CORE_CODE, 8'h05);
    wr(ADDR_CTRL2, 8'h87);
    wait_go();
    cmp("core fast", 8'h05, {3'h0, core_converter_output});
    core_slew_setting = 3'h6;
    wr(ADDR_CORE_CODE, 8'h08);
    wr(ADDR_CTRL2, 8'h87);
    tick(10);
    cmp("core held", 8'h05, {3'h0, core_converter_output});
    wait_go();
    cmp("ramp span", 8'h01, {7'h0, n >= 80 && n <= 112});
    cmp("core slow", 8'h08, {3'h0, core_converter_output});
    // downward ramp, two steps at the next slower rate
    core_slew_setting = 3'h5;
    wr(ADDR_CORE_CODE, 8'h06);
    wr(ADDR_CTRL2, 8'h87);
    wait_go();
    cmp("ramp down", 8'h01, {7'h0, n >= 130 && n <= 150});
    cmp("core down", 8'h06, {3'h0, core_converter_output});
    // reload events with both strap levels
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CORE_CODE, 8'h03);
      wr(ADDR_CTRL2, 8'h07);
      core_default_select_pin = k[0];
      case (k)
        0: warm_reset_input_n = 1'b0;
        1: power_on_reset_output = 1'b1;
        default: backup_rail_low = 1'b1;
      endcase
      tick(8);
      warm_reset_input_n = 1'b1;
      power_on_reset_output = 1'b0;
      backup_rail_low = 1'b0;
      tick(10);
      rd(ADDR_CTRL2, 8'h47);
      rd(ADDR_CORE_CODE, k[0] ? 8'h1E : 8'h14);
      cmp("core out", k[0] ? 8'h1E : 8'h14, {3'h0, core_converter_output});
    end
    // lockout reload, write during lockout lost
    wr(ADDR_MODE_CTRL, 8'h00);
    wr(ADDR_RAIL_EN, 8'h00);
    wr(ADDR_CTRL2, 8'h07);
    undervoltage_lockout = 1'b1;
    tick(8);
    wr(ADDR_MODE_CTRL, 8'h00);
    undervoltage_lockout = 1'b0;
    tick(10);
    defaults();
    // mid-run reset with the strap high
    core_default_select_pin = 1'b1;
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(8);
    rd(ADDR_CORE_CODE, 8'h1E);
    cmp("core out", 8'h1E, {3'h0, core_converter_output});
    report_and_stop();
  end
endmodule
